// File: rtl/tls_pkg.sv
// Constants, register map and carrier types of the torque limit selector.
// Operation
// - Forward and reverse torque of a rotary motor always capped by their internal limit settings.
// - Rotary internal limits accept 0 to 800 percent, default 800, immediate.
// - Linear force limits accept 0 to 800 percent, default 30, immediate.
// - Forward input on: smaller of forward internal and external limit applies.
// - Reverse input on: smaller of reverse internal and external limit applies.
// - Linear motors use force limits in place of internal torque limits.
// - Any applied limit above motor maximum torque is clamped to it.
// - In speed or position control a command enables a parameter torque limit.
// - External limits accept 0 to 800 percent, default 100, immediate.
package tls_pkg;

  localparam int AW = 8;
  localparam int DW = 16;
  localparam int PW = 10;
  localparam int NCFG = 8;
  localparam int NTERM = 8;

  // Largest accepted percentage; writes above it saturate.
  localparam logic [PW-1:0] PCT_MAX = 10'h320;

  // Percentage register indices; byte offset is four times the index.
  localparam logic [2:0] IDX_FWD_INT = 3'h0;
  localparam logic [2:0] IDX_REV_INT = 3'h1;
  localparam logic [2:0] IDX_FWD_EXT = 3'h2;
  localparam logic [2:0] IDX_REV_EXT = 3'h3;
  localparam logic [2:0] IDX_FWD_FORCE = 3'h4;
  localparam logic [2:0] IDX_REV_FORCE = 3'h5;
  localparam logic [2:0] IDX_MOTOR_MAX = 3'h6;
  localparam logic [2:0] IDX_CW_LIMIT = 3'h7;

  localparam logic [AW-1:0] OFF_CTRL = 8'h20;
  localparam logic [AW-1:0] OFF_ALLOC = 8'h24;
  localparam logic [AW-1:0] OFF_STATUS = 8'h28;
  localparam logic [AW-1:0] OFF_FWD_ACT = 8'h2C;
  localparam logic [AW-1:0] OFF_REV_ACT = 8'h30;

  // Reset values, entry 7 first.
  localparam logic [NCFG-1:0][PW-1:0] CFG_RST = {10'h064, 10'h320, 10'h01E, 10'h01E,
                                                 10'h064, 10'h064, 10'h320, 10'h320};

  // Control register fields.
  localparam int CTRL_LIN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_CW_BIT = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;

  // Allocation register: terminal number per direction, bit 3 set means unallocated.
  localparam int ALLOC_FWD_LSB = 0;
  localparam int ALLOC_REV_LSB = 4;
  localparam logic [7:0] ALLOC_RST = 8'h88;

  typedef enum logic [1:0] {
    TLS_MODE_SPEED = 2'b00,
    TLS_MODE_POSITION = 2'b01,
    TLS_MODE_TORQUE = 2'b10
  } tls_mode_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
  } tls_bus_t;

  typedef struct packed {
    logic [PW-1:0] fwd;
    logic [PW-1:0] rev;
  } tls_lim_t;

  typedef struct packed {
    logic [NCFG-1:0][PW-1:0] cfg;
    logic [3:0] ctrl;
    logic [7:0] alloc;
    logic [NTERM-1:0] sync1;
    logic [NTERM-1:0] sync2;
    logic fwd_on;
    logic rev_on;
    tls_lim_t lim;
    logic [DW-1:0] rdata;
  } tls_state_t;

endpackage : tls_pkg

// File: rtl/tls_selector.sv
// Torque limit selector: register port, terminal sampling and per-direction limit choice.
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
module tls_selector
  import tls_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Register port.
  input wire tls_bus_t bus,
  output logic [DW-1:0] rdata,
  // Input terminals, high while closed.
  input wire logic [NTERM-1:0] term_in,
  // Applied limits in percent.
  output tls_lim_t lim
);

  tls_state_t s_q;
  tls_state_t s_d;
  logic [PW-1:0] wval;
  logic [PW-1:0] fwd_base;
  logic [PW-1:0] rev_base;
  logic [PW-1:0] fwd_new;
  logic [PW-1:0] rev_new;
  logic [3:0] fwd_term;
  logic [3:0] rev_term;
  logic cw_act;
  logic in_cfg;

  always_comb begin
    s_d = s_q;
    s_d.sync1 = term_in;
    s_d.sync2 = s_q.sync1;
    wval = (bus.wdata > DW'(PCT_MAX)) ? PCT_MAX : bus.wdata[PW-1:0];
    in_cfg = (bus.addr[AW-1:5] == 3'h0) && (bus.addr[1:0] == 2'h0);
    if (bus.wr) begin
      if (in_cfg) begin
        s_d.cfg[bus.addr[4:2]] = wval;
      end else if (bus.addr == OFF_CTRL) begin
        s_d.ctrl = bus.wdata[3:0];
      end else if (bus.addr == OFF_ALLOC) begin
        s_d.alloc = bus.wdata[7:0];
      end
    end
    fwd_term = s_q.alloc[ALLOC_FWD_LSB +: 4];
    rev_term = s_q.alloc[ALLOC_REV_LSB +: 4];
    s_d.fwd_on = !fwd_term[3] && s_q.sync2[fwd_term[2:0]];
    s_d.rev_on = !rev_term[3] && s_q.sync2[rev_term[2:0]];
    fwd_base = s_q.ctrl[CTRL_LIN_BIT] ? s_q.cfg[IDX_FWD_FORCE] : s_q.cfg[IDX_FWD_INT];
    rev_base = s_q.ctrl[CTRL_LIN_BIT] ? s_q.cfg[IDX_REV_FORCE] : s_q.cfg[IDX_REV_INT];
    cw_act = s_q.ctrl[CTRL_CW_BIT] && (s_q.ctrl[CTRL_MODE_LSB +: 2] != TLS_MODE_TORQUE);
    // Internal limit, or force limit for a linear motor, is the starting cap.
    fwd_new = fwd_base;
    rev_new = rev_base;
    if (s_q.fwd_on && (s_q.cfg[IDX_FWD_EXT] < fwd_new)) begin
      fwd_new = s_q.cfg[IDX_FWD_EXT];
    end
    if (s_q.rev_on && (s_q.cfg[IDX_REV_EXT] < rev_new)) begin
      rev_new = s_q.cfg[IDX_REV_EXT];
    end
    if (cw_act && (s_q.cfg[IDX_CW_LIMIT] < fwd_new)) begin
      fwd_new = s_q.cfg[IDX_CW_LIMIT];
    end
    if (cw_act && (s_q.cfg[IDX_CW_LIMIT] < rev_new)) begin
      rev_new = s_q.cfg[IDX_CW_LIMIT];
    end
    if (s_q.cfg[IDX_MOTOR_MAX] < fwd_new) begin
      fwd_new = s_q.cfg[IDX_MOTOR_MAX];
    end
    if (s_q.cfg[IDX_MOTOR_MAX] < rev_new) begin
      rev_new = s_q.cfg[IDX_MOTOR_MAX];
    end
    s_d.lim.fwd = fwd_new;
    s_d.lim.rev = rev_new;
    // Read data stands only in the cycle after the strobe; unmapped reads give zero.
    s_d.rdata = '0;
    if (bus.rd) begin
      if ((bus.addr[AW-1:5] == 3'h0) && (bus.addr[1:0] == 2'h0)) begin
        s_d.rdata = DW'(s_q.cfg[bus.addr[4:2]]);
      end else if (bus.addr == OFF_CTRL) begin
        s_d.rdata = DW'(s_q.ctrl);
      end else if (bus.addr == OFF_ALLOC) begin
        s_d.rdata = DW'(s_q.alloc);
      end else if (bus.addr == OFF_STATUS) begin
        s_d.rdata = DW'({cw_act, s_q.rev_on, s_q.fwd_on});
      end else if (bus.addr == OFF_FWD_ACT) begin
        s_d.rdata = DW'(s_q.lim.fwd);
      end else if (bus.addr == OFF_REV_ACT) begin
        s_d.rdata = DW'(s_q.lim.rev);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.cfg <= CFG_RST;
      s_q.ctrl <= CTRL_RST;
      s_q.alloc <= ALLOC_RST;
      s_q.sync1 <= '0;
      s_q.sync2 <= '0;
      s_q.fwd_on <= 1'b0;
      s_q.rev_on <= 1'b0;
      s_q.lim.fwd <= CFG_RST[IDX_MOTOR_MAX];
      s_q.lim.rev <= CFG_RST[IDX_MOTOR_MAX];
      s_q.rdata <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign lim = s_q.lim;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_int_cap;
    !s_q.ctrl[CTRL_LIN_BIT] |=> (lim.fwd <= $past(s_q.cfg[IDX_FWD_INT])) && (lim.rev <= $past(s_q.cfg[IDX_REV_INT]));
  endproperty
  a_int_cap: assert property (p_int_cap) else $error("internal torque cap exceeded");

  property p_int_range;
    bus.wr && (bus.addr == 8'h00) && (bus.wdata > 16'h0320) |=> s_q.cfg[IDX_FWD_INT] == PCT_MAX;
  endproperty
  a_int_range: assert property (p_int_range) else $error("forward internal limit not saturated");

  property p_force_write;
    bus.wr && (bus.addr == 8'h14) && (bus.wdata <= 16'h0320) |=> s_q.cfg[IDX_REV_FORCE] == $past(bus.wdata[PW-1:0]);
  endproperty
  a_force_write: assert property (p_force_write) else $error("reverse force limit not stored");

  property p_fwd_ext;
    s_q.fwd_on && !s_q.ctrl[CTRL_LIN_BIT] |=> lim.fwd <= $past(s_q.cfg[IDX_FWD_EXT]);
  endproperty
  a_fwd_ext: assert property (p_fwd_ext) else $error("forward external limit ignored");

  property p_rev_off;
    !s_q.rev_on && !cw_act && !s_q.ctrl[CTRL_LIN_BIT] && (s_q.cfg[IDX_MOTOR_MAX] == PCT_MAX)
      |=> lim.rev == $past(s_q.cfg[IDX_REV_INT]);
  endproperty
  a_rev_off: assert property (p_rev_off) else $error("reverse limit wrong with input off");

  property p_linear;
    s_q.ctrl[CTRL_LIN_BIT] |=> (lim.fwd <= $past(s_q.cfg[IDX_FWD_FORCE])) && (lim.rev <= $past(s_q.cfg[IDX_REV_FORCE]));
  endproperty
  a_linear: assert property (p_linear) else $error("force limit not applied");

  property p_max_clamp;
    ##1 (lim.fwd <= $past(s_q.cfg[IDX_MOTOR_MAX])) && (lim.rev <= $past(s_q.cfg[IDX_MOTOR_MAX]));
  endproperty
  a_max_clamp: assert property (p_max_clamp) else $error("limit above motor maximum");

  property p_cw;
    cw_act |=> (lim.fwd <= $past(s_q.cfg[IDX_CW_LIMIT])) && (lim.rev <= $past(s_q.cfg[IDX_CW_LIMIT]));
  endproperty
  a_cw: assert property (p_cw) else $error("command torque limit not applied");

  property p_ext_range;
    bus.wr && (bus.addr == 8'h0C) && (bus.wdata > 16'h0320) |=> s_q.cfg[IDX_REV_EXT] == PCT_MAX;
  endproperty
  a_ext_range: assert property (p_ext_range) else $error("reverse external limit not saturated");

  property p_latency;
    !fwd_term[3] && $stable(s_q.alloc) [*4] ##0 $rose(term_in[fwd_term[2:0]]) |-> ##3 s_q.fwd_on;
  endproperty
  a_latency: assert property (p_latency) else $error("forward input not seen in three cycles");

  property p_rev_ext;
    s_q.rev_on && !s_q.ctrl[CTRL_LIN_BIT] |=> lim.rev <= $past(s_q.cfg[IDX_REV_EXT]);
  endproperty
  a_rev_ext: assert property (p_rev_ext) else $error("reverse external limit ignored");

  property p_fwd_off;
    !s_q.fwd_on && !cw_act && !s_q.ctrl[CTRL_LIN_BIT] && (s_q.cfg[IDX_MOTOR_MAX] == PCT_MAX)
      |=> lim.fwd == $past(s_q.cfg[IDX_FWD_INT]);
  endproperty
  a_fwd_off: assert property (p_fwd_off) else $error("forward limit wrong with input off");

  property p_lin_fwd_ext;
    s_q.ctrl[CTRL_LIN_BIT] && s_q.fwd_on |=> lim.fwd <= $past(s_q.cfg[IDX_FWD_EXT]);
  endproperty
  a_lin_fwd_ext: assert property (p_lin_fwd_ext) else $error("forward external force limit ignored");

  property p_lin_rev_ext;
    s_q.ctrl[CTRL_LIN_BIT] && s_q.rev_on |=> lim.rev <= $past(s_q.cfg[IDX_REV_EXT]);
  endproperty
  a_lin_rev_ext: assert property (p_lin_rev_ext) else $error("reverse external force limit ignored");

  property p_int_write;
    bus.wr && (bus.addr == 8'h00) && (bus.wdata <= 16'h0320) |=> s_q.cfg[IDX_FWD_INT] == $past(bus.wdata[PW-1:0]);
  endproperty
  a_int_write: assert property (p_int_write) else $error("forward internal limit not stored");

  property p_ext_write;
    bus.wr && (bus.addr == 8'h08) && (bus.wdata <= 16'h0320) |=> s_q.cfg[IDX_FWD_EXT] == $past(bus.wdata[PW-1:0]);
  endproperty
  a_ext_write: assert property (p_ext_write) else $error("forward external limit not stored");

  property p_fwd_force_write;
    bus.wr && (bus.addr == 8'h10) && (bus.wdata <= 16'h0320) |=> s_q.cfg[IDX_FWD_FORCE] == $past(bus.wdata[PW-1:0]);
  endproperty
  a_fwd_force_write: assert property (p_fwd_force_write) else $error("forward force limit not stored");

  property p_alloc_fwd;
    fwd_term[3] |=> !s_q.fwd_on;
  endproperty
  a_alloc_fwd: assert property (p_alloc_fwd) else $error("unallocated forward input acted");

  property p_alloc_rev;
    rev_term[3] |=> !s_q.rev_on;
  endproperty
  a_alloc_rev: assert property (p_alloc_rev) else $error("unallocated reverse input acted");

  property p_on_track;
    !fwd_term[3] |=> s_q.fwd_on == $past(s_q.sync2[fwd_term[2:0]]);
  endproperty
  a_on_track: assert property (p_on_track) else $error("forward input state not refreshed");

endmodule : tls_selector

// File: sim/tls_host.sv
// Host controller model that drives the discrete limit terminals.
`timescale 1ns/100ps
module tls_host (
  // Clock.
  input wire logic mclk,
  // Requested contact states and the terminals they are wired to.
  input wire logic fwd_on,
  input wire logic rev_on,
  input wire logic [2:0] fwd_term,
  input wire logic [2:0] rev_term,
  // Terminal lines, high while closed.
  output logic [7:0] term_in = 8'h00
);
  logic [7:0] noise_q = 8'h5A;
  logic [7:0] sel;
  always_comb begin
    sel = noise_q;
    sel[fwd_term] = fwd_on;
    sel[rev_term] = rev_on;
  end
  // Unused terminals toggle every cycle so that a stray decode shows up.
  always_ff @(posedge mclk) begin
    noise_q <= ~noise_q;
    term_in <= sel;
  end
endmodule : tls_host

// File: sim/tls_selector_bench.sv
// Self-checking bench of the torque limit selector.
`timescale 1ns/100ps
`define CHK(nm, ex, sn) begin comparisons++; if ((sn) !== (ex)) begin err_count++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, sn); end end
module tls_selector_bench;
  import tls_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  tls_bus_t bus = '0;
  logic [DW-1:0] rdata;
  tls_lim_t lim;
  logic [NTERM-1:0] term_in;
  logic fwd_on = 1'b0;
  logic rev_on = 1'b0;
  logic rd_d = 1'b0;
  int err_count = 0;
  int comparisons = 0;
  int seed = 81;
  logic [DW-1:0] exp_q[$];
  tls_lim_t lim_q[$];
  tls_lim_t lv;
  logic [DW-1:0] v;
  logic [AW-1:0] a;
  logic [PW-1:0] cfg[NCFG];
  logic [3:0] ctrl;
  always #5 mclk = ~mclk;
  tls_selector dut_u (.mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .term_in(term_in), .lim(lim));
  tls_host host_u (.mclk(mclk), .fwd_on(fwd_on), .rev_on(rev_on), .fwd_term(3'h2), .rev_term(3'h5),
    .term_in(term_in));
  function automatic logic [PW-1:0] lmin(input logic [PW-1:0] x, input logic [PW-1:0] y);
    return (x < y) ? x : y;
  endfunction : lmin
  // Expected applied limit, direction 0 forward and 1 reverse.
  function automatic logic [PW-1:0] expect_lim(input int d);
    logic [PW-1:0] m;
    m = ctrl[0] ? cfg[4 + d] : cfg[d];
    if (d == 0 ? fwd_on : rev_on) m = lmin(m, cfg[2 + d]);
    if (ctrl[3] && ctrl[2:1] != 2'b10) m = lmin(m, cfg[7]);
    return lmin(m, cfg[6]);
  endfunction : expect_lim
  task automatic wr(input logic [AW-1:0] ad, input logic [DW-1:0] d);
    @(posedge mclk);
    bus <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
    if (ad < OFF_CTRL) cfg[ad[4:2]] = (d > DW'(PCT_MAX)) ? PCT_MAX : d[PW-1:0];
    if (ad == OFF_CTRL) ctrl = d[3:0];
  endtask : wr
  task automatic rd(input logic [AW-1:0] ad, input logic [DW-1:0] e);
    @(posedge mclk);
    bus <= '{addr: ad, wdata: '0, wr: 1'b0, rd: 1'b1};
    exp_q.push_back(e);
    @(posedge mclk);
    bus.rd <= 1'b0;
  endtask : rd
  task automatic check_lim();
    repeat (6) @(posedge mclk);
    lim_q.push_back('{fwd: expect_lim(0), rev: expect_lim(1)});
    rd(OFF_FWD_ACT, DW'(expect_lim(0)));
    rd(OFF_REV_ACT, DW'(expect_lim(1)));
  endtask : check_lim
  task automatic report_and_stop();
    if (err_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  // Read data stand only in the cycle after the read strobe.
  always @(posedge mclk) rd_d <= bus.rd;
  always @(negedge mclk) begin
    if (rd_d === 1'b1) begin
      v = exp_q.pop_front();
      `CHK("rdata", v, rdata)
    end else begin
      `CHK("rdata idle", 16'h0000, rdata)
    end
    if (lim_q.size() > 0) begin
      lv = lim_q.pop_front();
      `CHK("lim.fwd", lv.fwd, lim.fwd)
      `CHK("lim.rev", lv.rev, lim.rev)
    end
  end
  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end
  initial begin
    for (int i = 0; i < NCFG; i++) cfg[i] = CFG_RST[i];
    ctrl = CTRL_RST;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < NCFG; i++) rd(AW'(4 * i), DW'(CFG_RST[i]));
    rd(OFF_ALLOC, 16'h0088);
    rd(8'h40, 16'h0000);
    check_lim();
    wr(OFF_ALLOC, 16'h0052);
    wr(8'h00, 16'h0384);
    rd(8'h00, 16'h0320);
    wr(8'h0C, 16'h8001);
    rd(8'h0C, 16'h0320);
    for (int k = 0; k < 12; k++) begin
      a = AW'(4 * ($unsigned($random(seed)) % 4));
      wr(a, DW'($unsigned($random(seed)) % 1024));
      rd(a, DW'(cfg[a[4:2]]));
      fwd_on <= k[0];
      rev_on <= k[1];
      check_lim();
      rd(OFF_STATUS, {14'h0000, rev_on, fwd_on});
    end
    wr(OFF_CTRL, 16'h0001);
    check_lim();
    wr(8'h10, DW'($unsigned($random(seed)) % 801));
    wr(8'h14, DW'($unsigned($random(seed)) % 801));
    check_lim();
    wr(8'h18, 16'h0014);
    check_lim();
    wr(8'h18, 16'h0320);
    wr(8'h1C, 16'h0028);
    for (int m = 0; m < 3; m++) begin
      wr(OFF_CTRL, DW'(8 | (m << 1)));
      check_lim();
    end
    wr(OFF_CTRL, 16'h0000);
    wr(8'h00, 16'h000A);
    rd(OFF_FWD_ACT, DW'(expect_lim(0)));
    repeat (3) @(posedge mclk);
    report_and_stop();
  end
endmodule : tls_selector_bench
